/* shared/ptx_map.svh */
// Offsets, field positions, reset values and timing figures of the
// 10Base-T operations and extended control registers.
// Assumes a 20 MHz management/core clock.
`ifndef PTX_MAP_SVH
`define PTX_MAP_SVH

// Register offsets on the management register port
`define PTX_OFS_TENOPS 5'h12
`define PTX_OFS_EXTCTL 5'h13

// Field positions, 10Base-T operations register
`define PTX_TO_RJAB 15
`define PTX_TO_POLREV 14
`define PTX_TO_JABINH 5
`define PTX_TO_APOLINH 3
`define PTX_TO_SQEINH 2
`define PTX_TO_LLINH 1
`define PTX_TO_SQLINH 0

// Field positions, extended control register
`define PTX_EC_NODREP 15
`define PTX_EC_HWSW 14
`define PTX_EC_RFAULT 13
`define PTX_EC_TRI 7
`define PTX_EC_AUTOPD 0

// Reset values of the writable parts (bit 18.4 reserved resets high)
`define PTX_TENOPS_RST 16'h0010
`define PTX_EXTCTL_RST 16'h0001
// Writable masks (19.10 is a read-only reserved bit)
`define PTX_TENOPS_WMASK 16'h3fff
`define PTX_EXTCTL_WMASK 16'h1bff

// Timing
`define PTX_CLK_MHZ 20
`define PTX_JABBER_MS 20
`define PTX_LINKLOSS_MS 50
`define PTX_SQE_NS 1000

`endif

/* shared/ptx_pkg.sv */
// Types shared by the PHY operations/extended-control register block.
// Assumes the constants of ptx_map.svh are included where needed.
package ptx_pkg;

  // Register access request from the management frame engine
  typedef struct packed {
    logic [4:0] addr;
    logic rd;
    logic wr;
    logic [15:0] wdata;
  } ptx_reg_req_t;

  // Register read answer
  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } ptx_reg_rsp_t;

  // 10Base-T link integrity states
  typedef enum logic [1:0] {
    PTX_LINK_FAIL,
    PTX_LINK_WAIT_IDLE,
    PTX_LINK_PASS
  } ptx_link_st_t;

endpackage

/* src/ptx_regs.sv */
// 10Base-T operations and extended control registers of a 10/100 PHY,
// with the small amount of port logic that they steer.
// Assumes register requests come from a management frame engine on i_mclk;
// line-side receive status inputs are asynchronous and are synchronised here; duplex, speed and remote fault inputs are used unsynchronised.
`timescale 1ns/1ps
`include "ptx_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Remote jabber latches high, read clears
// - Remote jabber only updates status bit
// - Jabber timing applied to receive activity
// - Polarity bit shows receive pair reversal
// - Jabber inhibit disables transmit jabber check
// - Auto polarity inhibit suppresses polarity correction
// - Polarity correction also applies at 100Base-TX
// - SQE inhibit disables SQE test generation
// - SQE pulses collision after transmit enable drops
// - Full duplex/repeater suppress SQE, bit unchanged
// - Link loss inhibit forces link passed
// - Squelch inhibit requires data then idle
// - Node/repeater bit read-only, strapped at reset
// - Node mode: SQE on, CRS on tx/rx
// - Software mode bit: registers set configuration
// - Remote fault mirrors standard remote fault bit
// - Tri-state control floats both transmit outputs
// - Auto power-down switches 100TX off in 10T
// - Isolate also powers 100TX transceiver down
module ptx_regs
  import ptx_pkg::*;
#(
  parameter int unsigned JAB_CYC = `PTX_JABBER_MS * `PTX_CLK_MHZ * 1000,
  parameter int unsigned LOSS_CYC = `PTX_LINKLOSS_MS * `PTX_CLK_MHZ * 1000
)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire ptx_reg_req_t i_reg_req,
  output ptx_reg_rsp_t o_reg_rsp,
  input wire logic i_tx_en,
  input wire logic i_rx_activity,
  input wire logic i_rx_valid_data,
  input wire logic i_rx_idle,
  input wire logic i_rx_pol_reversed,
  input wire logic i_node_repeater_select,
  input wire logic i_hw_sw_select,
  input wire logic i_full_duplex,
  input wire logic i_speed_100,
  input wire logic i_isolate,
  input wire logic i_remote_fault,
  input wire logic i_pair_tx_pos,
  input wire logic i_pair_tx_neg,
  output logic o_pair_tx_pos,
  output logic o_pair_tx_neg,
  output logic o_pair_tx_pos_oe,
  output logic o_pair_tx_neg_oe,
  output logic o_rx_pol_invert,
  output logic o_tx_jabber,
  output logic o_col_sqe,
  output logic o_crs,
  output logic o_link_pass,
  output logic o_tx100_pwrdn
);

  // SQE pulse length in cycles, rounded down, at least one
  localparam int unsigned SQE_RAW = (`PTX_SQE_NS * `PTX_CLK_MHZ) / 1000;
  localparam int unsigned SQE_CYC = (SQE_RAW < 1) ? 1 : SQE_RAW;
  localparam logic [19:0] JAB_LIM = JAB_CYC[19:0];
  localparam logic [19:0] LOSS_LIM = LOSS_CYC[19:0];
  localparam logic [7:0] SQE_LIM = SQE_CYC[7:0];

  // Saturating increment for activity timers
  function automatic logic [19:0] sat_inc(input logic [19:0] v);
    logic [19:0] r;
    r = (v == 20'hfffff) ? v : v + 20'h00001;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: stage one is read only by stage two
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end
    else
    begin
      sync1_q <= {i_hw_sw_select, i_node_repeater_select, i_rx_pol_reversed,
                  i_rx_idle, i_rx_valid_data, i_rx_activity, i_tx_en};
      sync2_q <= sync1_q;
    end
  end

  logic tx_en_s;
  logic rx_act_s;
  logic rx_data_s;
  logic rx_idle_s;
  logic pol_rev_s;
  assign tx_en_s = sync2_q[0];
  assign rx_act_s = sync2_q[1];
  assign rx_data_s = sync2_q[2];
  assign rx_idle_s = sync2_q[3];
  assign pol_rev_s = sync2_q[4];

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture once the synchronisers hold real pin levels
  logic [1:0] strap_cnt_q;
  logic repeater_q; // Strapped node/repeater mode
  logic sw_mode_q; // Strapped software mode

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      strap_cnt_q <= 2'h0;
      repeater_q <= 1'b0;
      sw_mode_q <= 1'b1;
    end
    else if (strap_cnt_q != 2'h3)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2)
      begin
        repeater_q <= sync2_q[5];
        sw_mode_q <= sync2_q[6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable register bits
  logic [15:0] tenops_q;
  logic [15:0] extctl_q;
  logic rd_ops;
  logic rd_ext;
  assign rd_ops = i_reg_req.rd && (i_reg_req.addr == `PTX_OFS_TENOPS);
  assign rd_ext = i_reg_req.rd && (i_reg_req.addr == `PTX_OFS_EXTCTL);

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tenops_q <= `PTX_TENOPS_RST;
      extctl_q <= `PTX_EXTCTL_RST;
    end
    else if (i_reg_req.wr)
    begin
      // Reserved bits inside the write masks are stored as written; manager supplies defaults
      if (i_reg_req.addr == `PTX_OFS_TENOPS)
        tenops_q <= i_reg_req.wdata & `PTX_TENOPS_WMASK;
      else if (i_reg_req.addr == `PTX_OFS_EXTCTL)
        extctl_q <= i_reg_req.wdata & `PTX_EXTCTL_WMASK;
    end
  end

  // Effective controls: in hardware mode the reset defaults apply
  logic [15:0] ops_eff;
  logic [15:0] ext_eff;
  assign ops_eff = sw_mode_q ? tenops_q : `PTX_TENOPS_RST;
  assign ext_eff = sw_mode_q ? extctl_q : `PTX_EXTCTL_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit jabber check and receive-side remote jabber timers
  logic [19:0] tx_jab_cnt_q;
  logic [19:0] rx_jab_cnt_q;
  logic rjab_q; // Latched remote jabber
  logic rx_jab_hit;
  assign rx_jab_hit = rx_act_s && (rx_jab_cnt_q >= JAB_LIM);

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tx_jab_cnt_q <= 20'h00000;
      rx_jab_cnt_q <= 20'h00000;
    end
    else
    begin
      tx_jab_cnt_q <= tx_en_s ? sat_inc(tx_jab_cnt_q) : 20'h00000;
      rx_jab_cnt_q <= rx_act_s ? sat_inc(rx_jab_cnt_q) : 20'h00000;
    end
  end

  // Remote jabber flag: set wins over read clear; only status, no action
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      rjab_q <= 1'b0;
    else if (rx_jab_hit)
      rjab_q <= 1'b1;
    else if (rd_ops)
      rjab_q <= 1'b0;
  end

  // Transmit jabber: active unless inhibited, held while transmit enable stays
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_tx_jabber <= 1'b0;
    else
      o_tx_jabber <= !ops_eff[`PTX_TO_JABINH] && tx_en_s
                     && (tx_jab_cnt_q >= JAB_LIM);
  end

  ////////////////////////////////////////////////////////////////////////////
  // SQE test: collision pulse after transmit enable falls
  logic tx_en_d1_q;
  logic [7:0] sqe_cnt_q;
  logic sqe_allow;
  assign sqe_allow = !ops_eff[`PTX_TO_SQEINH]
                     && !i_full_duplex && !repeater_q
                     && !i_speed_100;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tx_en_d1_q <= 1'b0;
      sqe_cnt_q <= 8'h00;
      o_col_sqe <= 1'b0;
    end
    else
    begin
      tx_en_d1_q <= tx_en_s;
      if (tx_en_d1_q && !tx_en_s && sqe_allow)
      begin
        sqe_cnt_q <= SQE_LIM;
        o_col_sqe <= 1'b1;
      end
      else if (sqe_cnt_q > 8'h01)
        sqe_cnt_q <= sqe_cnt_q - 8'h01;
      else
      begin
        sqe_cnt_q <= 8'h00;
        o_col_sqe <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 10Base-T link integrity
  ptx_link_st_t link_q;
  logic [19:0] quiet_cnt_q;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      link_q <= PTX_LINK_FAIL;
      quiet_cnt_q <= 20'h00000;
    end
    else if (ops_eff[`PTX_TO_LLINH])
    begin
      link_q <= PTX_LINK_PASS;
      quiet_cnt_q <= 20'h00000;
    end
    else
    begin
      // Loss timer runs only while passed, so a fresh pass is not dropped at once
      quiet_cnt_q <= (rx_act_s || (link_q != PTX_LINK_PASS)) ? 20'h00000
                                                               : sat_inc(quiet_cnt_q);
      unique case (link_q)
        PTX_LINK_FAIL:
          if (rx_data_s)
            link_q <= ops_eff[`PTX_TO_SQLINH] ? PTX_LINK_WAIT_IDLE
                                              : PTX_LINK_PASS;
        PTX_LINK_WAIT_IDLE:
          if (rx_idle_s)
            link_q <= PTX_LINK_PASS;
        PTX_LINK_PASS:
          if (quiet_cnt_q >= LOSS_LIM)
            link_q <= PTX_LINK_FAIL;
        default:
          link_q <= PTX_LINK_FAIL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port-side outputs
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pair_tx_pos <= 1'b0;
      o_pair_tx_neg <= 1'b0;
      o_pair_tx_pos_oe <= 1'b0;
      o_pair_tx_neg_oe <= 1'b0;
      o_rx_pol_invert <= 1'b0;
      o_crs <= 1'b0;
      o_link_pass <= 1'b0;
      o_tx100_pwrdn <= 1'b0;
    end
    else
    begin
      o_pair_tx_pos <= i_pair_tx_pos;
      o_pair_tx_neg <= i_pair_tx_neg;
      o_pair_tx_pos_oe <= !ext_eff[`PTX_EC_TRI];
      o_pair_tx_neg_oe <= !ext_eff[`PTX_EC_TRI];
      // Correction in both speeds unless inhibited
      o_rx_pol_invert <= pol_rev_s && !ops_eff[`PTX_TO_APOLINH];
      // Node mode: carrier on transmit or receive; repeater: receive only
      o_crs <= rx_act_s || (tx_en_s && !repeater_q);
      o_link_pass <= (link_q == PTX_LINK_PASS);
      o_tx100_pwrdn <= i_isolate
                       || (ext_eff[`PTX_EC_AUTOPD] && !i_speed_100);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read path, one cycle after the read strobe
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_reg_rsp <= '0;
    else
    begin
      o_reg_rsp.valid <= i_reg_req.rd;
      if (rd_ops)
      begin
        o_reg_rsp.rdata <= tenops_q;
        o_reg_rsp.rdata[`PTX_TO_RJAB] <= rjab_q;
        o_reg_rsp.rdata[`PTX_TO_POLREV] <= pol_rev_s;
      end
      else if (rd_ext)
      begin
        o_reg_rsp.rdata <= extctl_q;
        o_reg_rsp.rdata[`PTX_EC_NODREP] <= repeater_q;
        o_reg_rsp.rdata[`PTX_EC_HWSW] <= sw_mode_q;
        o_reg_rsp.rdata[`PTX_EC_RFAULT] <= i_remote_fault;
      end
      else
        o_reg_rsp.rdata <= 16'h0000;
    end
  end

endmodule

/* verif/ptx_assertions.sv */
// Port checks of the register block.
// Assumes a bind into every ptx_regs.
`timescale 1ns/1ps
module ptx_assertions
  import ptx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire ptx_reg_req_t i_reg_req,
  input wire ptx_reg_rsp_t o_reg_rsp,
  input wire logic i_hw_sw_select,
  input wire logic i_full_duplex,
  input wire logic i_isolate,
  input wire logic i_remote_fault,
  input wire logic i_rx_activity,
  input wire logic o_pair_tx_pos_oe,
  input wire logic o_col_sqe,
  input wire logic o_crs,
  input wire logic o_tx100_pwrdn
);
  // One clock, reset masks all
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  // Register port
  property p_rsp;
    i_reg_req.rd |=> o_reg_rsp.valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
  property p_quiet;
    !i_reg_req.rd |=> !o_reg_rsp.valid && o_reg_rsp.rdata == 16'h0000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_unmap;
    i_reg_req.rd && i_reg_req.addr[4:1] != 4'h9 |=> o_reg_rsp.rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_rfault;
    i_reg_req.rd && i_reg_req.addr == 5'h13 |=>
      o_reg_rsp.rdata[13] == $past(i_remote_fault);
  endproperty
  a_rfault: assert property (p_rfault) else $error("fault bit");
  ////////////////////////////////////////
  // Line side
  property p_tri;
    i_reg_req.wr && i_reg_req.addr == 5'h13 && i_reg_req.wdata[7] &&
      i_hw_sw_select |-> ##2 !o_pair_tx_pos_oe;
  endproperty
  a_tri: assert property (p_tri) else $error("pair driven");
  property p_sqe_fd;
    i_full_duplex [*4] |-> !$rose(o_col_sqe);
  endproperty
  a_sqe_fd: assert property (p_sqe_fd) else $error("sqe in duplex");
  property p_sqe_len;
    $rose(o_col_sqe) |-> o_col_sqe [*8];
  endproperty
  a_sqe_len: assert property (p_sqe_len) else $error("sqe short");
  property p_iso;
    i_isolate [*2] |-> ##[0:2] o_tx100_pwrdn;
  endproperty
  a_iso: assert property (p_iso) else $error("100 on");
  property p_crs;
    i_rx_activity [*4] |-> ##[0:2] o_crs;
  endproperty
  a_crs: assert property (p_crs) else $error("no carrier");
endmodule
bind ptx_regs ptx_assertions u_chk (
  .i_mclk(i_mclk),
  .i_rst(i_rst),
  .i_reg_req(i_reg_req),
  .o_reg_rsp(o_reg_rsp),
  .i_hw_sw_select(i_hw_sw_select),
  .i_full_duplex(i_full_duplex),
  .i_isolate(i_isolate),
  .i_remote_fault(i_remote_fault),
  .i_rx_activity(i_rx_activity),
  .o_pair_tx_pos_oe(o_pair_tx_pos_oe),
  .o_col_sqe(o_col_sqe),
  .o_crs(o_crs),
  .o_tx100_pwrdn(o_tx100_pwrdn)
);

/* verif/ptx_sme.sv */
// Station management model issuing register requests.
// Assumes calls only after reset is released.
`timescale 1ns/1ps
module ptx_sme
  import ptx_pkg::*;
(
  input wire logic i_mclk,
  input wire ptx_reg_rsp_t i_rsp,
  output ptx_reg_req_t o_req
);
  initial o_req = '0;
  // One-cycle write, reserved bits at defaults
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = (a == 5'h12) ? ((d & 16'h002f) | 16'h0010) : (d & 16'h0081);
    @(posedge i_mclk);
    o_req <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: v};
    @(posedge i_mclk);
    o_req <= '{addr: a, rd: 1'b0, wr: 1'b0, wdata: ~v};
  endtask
  // One-cycle read, answer taken next edge
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(posedge i_mclk);
    o_req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 16'h0000};
    @(posedge i_mclk);
    o_req.rd <= 1'b0;
    @(posedge i_mclk);
    q = i_rsp.valid ? i_rsp.rdata : 'x;
  endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench of the register block.
// Assumes the management model sits on the register port.
`timescale 1ns/1ps
module tb_top
  import ptx_pkg::*;
;
  logic i_mclk = 0, i_rst = 1;
  ptx_reg_req_t i_reg_req;
  ptx_reg_rsp_t o_reg_rsp;
  logic i_tx_en = 0, i_rx_activity = 0, i_rx_valid_data = 0, i_rx_idle = 0;
  logic i_rx_pol_reversed = 0, i_node_repeater_select = 0, i_hw_sw_select = 1;
  logic i_full_duplex = 0, i_speed_100 = 0, i_isolate = 0, i_remote_fault = 0;
  logic i_pair_tx_pos = 1, i_pair_tx_neg = 0;
  logic o_pair_tx_pos, o_pair_tx_neg, o_pair_tx_pos_oe, o_pair_tx_neg_oe;
  logic o_rx_pol_invert, o_tx_jabber, o_col_sqe, o_crs, o_link_pass, o_tx100_pwrdn;
  int err_total = 0, samples_checked = 0, cycles = 0;
  logic [15:0] q;
  always #25 i_mclk = ~i_mclk;
  ptx_regs #(.JAB_CYC(50), .LOSS_CYC(100)) u_dut (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_reg_req(i_reg_req),
    .o_reg_rsp(o_reg_rsp),
    .i_tx_en(i_tx_en),
    .i_rx_activity(i_rx_activity),
    .i_rx_valid_data(i_rx_valid_data),
    .i_rx_idle(i_rx_idle),
    .i_rx_pol_reversed(i_rx_pol_reversed),
    .i_node_repeater_select(i_node_repeater_select),
    .i_hw_sw_select(i_hw_sw_select),
    .i_full_duplex(i_full_duplex),
    .i_speed_100(i_speed_100),
    .i_isolate(i_isolate),
    .i_remote_fault(i_remote_fault),
    .i_pair_tx_pos(i_pair_tx_pos),
    .i_pair_tx_neg(i_pair_tx_neg),
    .o_pair_tx_pos(o_pair_tx_pos),
    .o_pair_tx_neg(o_pair_tx_neg),
    .o_pair_tx_pos_oe(o_pair_tx_pos_oe),
    .o_pair_tx_neg_oe(o_pair_tx_neg_oe),
    .o_rx_pol_invert(o_rx_pol_invert),
    .o_tx_jabber(o_tx_jabber),
    .o_col_sqe(o_col_sqe),
    .o_crs(o_crs),
    .o_link_pass(o_link_pass),
    .o_tx100_pwrdn(o_tx100_pwrdn)
  );
  ptx_sme u_sme (.i_mclk(i_mclk), .i_rsp(o_reg_rsp), .o_req(i_reg_req));
  ////////////////////////////////////////
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Single-bit output compare
  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    u_sme.rd(a, q);
    chk(q, e);
  endtask
  // Counts collision pulse cycles after a short frame
  task automatic sqe(input logic [15:0] e);
    int n;
    n = 0;
    i_tx_en <= 1;
    cyc(10);
    i_tx_en <= 0;
    repeat (30)
    begin
      @(posedge i_mclk);
      n += o_col_sqe;
    end
    chk(16'(n), e);
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      complete_run;
    end
  end
  ////////////////////////////////////////
  // Tests
  initial
  begin
    cyc(20);
    i_rst <= 0;
    cyc(5);
    rdc(5'h12, 16'h0010);
    rdc(5'h13, 16'h4001);
    rdc(5'h05, 16'h0000);
    $display("test 1 done");
    chk_bit(o_tx100_pwrdn, 1'b1);
    u_sme.wr(5'h13, 16'h0000);
    cyc(3);
    chk_bit(o_tx100_pwrdn, 1'b0);
    i_isolate <= 1'b1;
    cyc(4);
    chk_bit(o_tx100_pwrdn, 1'b1);
    i_isolate <= 1'b0;
    i_remote_fault <= 1'b1;
    u_sme.wr(5'h13, 16'h0081);
    cyc(2);
    chk({14'h0000, o_pair_tx_pos_oe, o_pair_tx_neg_oe}, 16'h0000);
    rdc(5'h13, 16'h6081);
    i_remote_fault <= 1'b0;
    u_sme.wr(5'h13, 16'h0001);
    cyc(2);
    chk({14'h0000, o_pair_tx_pos_oe, o_pair_tx_neg_oe}, 16'h0003);
    chk({14'h0000, o_pair_tx_pos, o_pair_tx_neg}, 16'h0002);
    $display("test 2 done");
    i_rx_pol_reversed <= 1'b1;
    i_speed_100 <= 1'b1;
    cyc(5);
    chk_bit(o_rx_pol_invert, 1'b1);
    rdc(5'h12, 16'h4010);
    u_sme.wr(5'h12, 16'h0008);
    cyc(2);
    chk_bit(o_rx_pol_invert, 1'b0);
    i_rx_pol_reversed <= 1'b0;
    i_speed_100 <= 1'b0;
    u_sme.wr(5'h12, 16'h0000);
    cyc(5);
    $display("test 3 done");
    sqe(16'h0014);
    i_full_duplex <= 1'b1;
    sqe(16'h0000);
    rdc(5'h12, 16'h0010);
    i_full_duplex <= 1'b0;
    u_sme.wr(5'h12, 16'h0004);
    sqe(16'h0000);
    u_sme.wr(5'h12, 16'h0000);
    $display("test 4 done");
    i_tx_en <= 1'b1;
    cyc(60);
    chk_bit(o_tx_jabber, 1'b1);
    chk_bit(o_crs, 1'b1);
    u_sme.wr(5'h12, 16'h0020);
    cyc(3);
    chk_bit(o_tx_jabber, 1'b0);
    i_tx_en <= 1'b0;
    u_sme.wr(5'h12, 16'h0000);
    cyc(25);
    i_rx_activity <= 1'b1;
    cyc(60);
    chk_bit(o_crs, 1'b1);
    chk_bit(o_tx_jabber, 1'b0);
    i_rx_activity <= 1'b0;
    cyc(5);
    rdc(5'h12, 16'h8010);
    rdc(5'h12, 16'h0010);
    $display("test 5 done");
    cyc(110);
    chk_bit(o_link_pass, 1'b0);
    u_sme.wr(5'h12, 16'h0002);
    cyc(3);
    chk_bit(o_link_pass, 1'b1);
    u_sme.wr(5'h12, 16'h0001);
    cyc(110);
    chk_bit(o_link_pass, 1'b0);
    i_rx_valid_data <= 1'b1;
    cyc(5);
    chk_bit(o_link_pass, 1'b0);
    i_rx_idle <= 1'b1;
    cyc(5);
    chk_bit(o_link_pass, 1'b1);
    $display("test 6 done");
    // Second reset with the repeater strap set
    i_node_repeater_select <= 1'b1;
    i_rst <= 1'b1;
    cyc(3);
    i_rst <= 1'b0;
    cyc(5);
    rdc(5'h13, 16'hc001);
    i_tx_en <= 1'b1;
    cyc(5);
    chk_bit(o_crs, 1'b0);
    i_tx_en <= 1'b0;
    cyc(5);
    sqe(16'h0000);
    $display("test 7 done");
    complete_run;
  end
endmodule
